// File: hw/iopes_top.sv
// Event selector: maps event code and umask onto a per-cycle counter increment
//
// Contract
// - Events exist only on counters 0 and 1, chosen by 8-bit code.
// - Codes 01-03 count data ingress inserts per class, at most 1.
// - 04-06 count full cycles; 07-09 add occupancy, at most 24.
// - 0d reports outbound request occupancy; 0e, 0f outbound data inserts.
// - Write-cache codes 10-14 may add up to 128 per cycle.
// - Code 17 counts inbound writes matching an address in the cache.
// - Umask bit 0 on 17 counts conflict stalls.
// - Code 14 adds writes holding ownership without delivered data.
// - Ack-pending rises on ack, falls on data return or tickle release.
// - One tickle may drop ack-pending by several writes at once.
// - Code 13 adds writes acquiring ownership; up on issue, down on data.
// - Umask 01 on cache events selects every source port.
// - Umask 02 selects the one filtered source queue only.
// - 18 and 19 count address and data egress credit stalls.
// - Code 00 adds one every unit clock.
// - Control holds event code in bits 7:0 and umask in 15:8.
`timescale 1ns/1ns
`default_nettype none
module iopes_top
    import iopes_pkg::*;
(
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // Register port
    input  wire logic [3:0]                 addr,
    input  wire logic [31:0]                wdata,
    input  wire logic                       wr_en,
    input  wire logic                       rd_en,
    output logic      [31:0]                rdata,
    // Unit status
    input  wire iopes_ev_t                  ev,
    input  wire iopes_wc_t                  wc,
    // Counter increments, counter 0 and 1
    output logic      [NUM_CTRS-1:0][INC_W-1:0] ctr_inc
);
    iopes_state_t s_reg;
    iopes_state_t s_next;

    // ========================================
    // Helpers
    function automatic logic [7:0] sat(input logic [9:0] v, input logic [7:0] mx);
        sat = (v > {2'b00, mx}) ? mx : v[7:0];
    endfunction : sat

    function automatic logic [OCC_W-1:0] trk(input logic [OCC_W-1:0] v,
                                             input logic up, input logic [2:0] dn);
        logic [OCC_W:0] t;
        t = {1'b0, v} + {{OCC_W{1'b0}}, up};
        trk = (t > {6'd0, dn}) ? OCC_W'(t - {6'd0, dn}) : '0;
    endfunction : trk

    function automatic logic [9:0] pick(input logic [NUM_SRC-1:0][OCC_W-1:0] a,
                                        input logic [7:0] um, input logic [SRC_W-1:0] sel);
        logic [9:0] acc;
        acc = '0;
        if (um == UM_SOURCE) begin
            acc = {2'b00, a[sel]};
        end else if (um == UM_ANY) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                acc = acc + {2'b00, a[i]};
            end
        end
        pick = acc;
    endfunction : pick

    // ========================================
    // Next-state logic
    always_comb begin
        logic [7:0] code;
        logic [7:0] um;
        logic [9:0] raw;
        logic [7:0] mx;
        code = '0;
        um = '0;
        raw = '0;
        mx = '0;
        s_next = s_reg;
        s_next.rdata = '0;
        // Trackers per source; clamp at zero guards a lost increment
        for (int i = 0; i < NUM_SRC; i++) begin
            s_next.rd[i] = trk(s_reg.rd[i], wc.rd_issue[i], {2'b00, wc.rd_done[i]});
            s_next.own[i] = trk(s_reg.own[i], wc.wr_issue[i],
                                {2'b00, wc.wr_done[i]});
            s_next.ack[i] = trk(s_reg.ack[i], wc.own_ack[i],
                                wc.tickle_rel[i] + {2'b00, wc.wr_done[i]});
        end
        // Register writes
        if (wr_en) begin
            case (addr)
                ADDR_CTL0:   s_next.ctl[0] = wdata[CTL_W-1:0];
                ADDR_CTL1:   s_next.ctl[1] = wdata[CTL_W-1:0];
                ADDR_FILTER: s_next.src_sel = wdata[SRC_W-1:0];
                default: ;
            endcase
        end
        // Register reads, answered next cycle
        if (rd_en) begin
            case (addr)
                ADDR_CTL0:   s_next.rdata = {16'h0000, s_reg.ctl[0]};
                ADDR_CTL1:   s_next.rdata = {16'h0000, s_reg.ctl[1]};
                ADDR_FILTER: s_next.rdata = {30'd0, s_reg.src_sel};
                ADDR_INC0:   s_next.rdata = {24'd0, s_reg.inc[0]};
                ADDR_INC1:   s_next.rdata = {24'd0, s_reg.inc[1]};
                default:     s_next.rdata = '0;
            endcase
        end
        // Event mux per counter; only two counters exist
        for (int c = 0; c < NUM_CTRS; c++) begin
            code = s_reg.ctl[c][CTL_UMASK_LSB-1:CTL_EV_LSB];
            um = s_reg.ctl[c][CTL_W-1:CTL_UMASK_LSB];
            raw = '0;
            mx = MAX_ONE;
            case (code)
                EV_CLOCK:      raw = 10'd1;
                EV_INS_RESP, EV_INS_NCB, EV_INS_NCS:
                    raw = {9'd0, ev.ins[code[1:0] - 2'd1]};
                EV_FULL_RESP, 8'h05, EV_FULL_NCS:
                    raw = {9'd0, ev.full[2'(code - EV_FULL_RESP)]};
                EV_OCC_RESP, 8'h08, EV_OCC_NCS: begin
                    raw = {5'd0, ev.occ[2'(code - EV_OCC_RESP)]};
                    mx = MAX_QUEUE;
                end
                EV_ACK_INS:    raw = {9'd0, ev.ack_ins};
                EV_ACK_FULL:   raw = {9'd0, ev.ack_full};
                EV_ACK_OCC: begin
                    raw = {5'd0, ev.ack_occ};
                    mx = MAX_QUEUE;
                end
                EV_OUT_REQ:    raw = {9'd0, ev.out_req};
                EV_OUT_NCB:    raw = {9'd0, ev.out_ins[0]};
                EV_OUT_NCS:    raw = {9'd0, ev.out_ins[1]};
                EV_C_READ: begin
                    raw = pick(s_reg.rd, um, s_reg.src_sel);
                    mx = MAX_CACHE;
                end
                EV_C_WRITE: begin
                    raw = pick(s_reg.own, um, s_reg.src_sel)
                        + pick(s_reg.ack, um, s_reg.src_sel);
                    mx = MAX_CACHE;
                end
                EV_C_TOTAL: begin
                    raw = pick(s_reg.rd, um, s_reg.src_sel)
                        + pick(s_reg.own, um, s_reg.src_sel)
                        + pick(s_reg.ack, um, s_reg.src_sel);
                    mx = MAX_CACHE;
                end
                EV_C_OWN: begin
                    raw = pick(s_reg.own, um, s_reg.src_sel);
                    mx = MAX_CACHE;
                end
                EV_C_ACKPEND: begin
                    raw = pick(s_reg.ack, um, s_reg.src_sel);
                    mx = MAX_CACHE;
                end
                EV_ADDR_MATCH:
                    raw = {9'd0, (um[0] & ev.conflict_stall)
                               | (um[1] & ev.conflict_merge)};
                EV_ADDR_STALL: raw = {9'd0, ev.addr_stall};
                EV_DATA_STALL: raw = {9'd0, ev.data_stall};
                default:       raw = '0;
            endcase
            s_next.inc[c] = sat(raw, mx);
        end
    end

    // ========================================
    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata = s_reg.rdata;
    assign ctr_inc = s_reg.inc;

    // ========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence clk_sel(int c);
        s_reg.ctl[c][7:0] == EV_CLOCK;
    endsequence

    a_clock_tick: assert property (clk_sel(0) ##1 clk_sel(0) |-> ctr_inc[0] == 8'h01)
        else $error("clock event did not add one");
    a_cache_max: assert property (ctr_inc[0] <= MAX_CACHE && ctr_inc[1] <= MAX_CACHE)
        else $error("increment above cache maximum");
    a_queue_max: assert property (s_reg.ctl[0][7:0] == EV_OCC_RESP ##1
                                  s_reg.ctl[0][7:0] == EV_OCC_RESP |-> ctr_inc[0] <= MAX_QUEUE)
        else $error("queue occupancy above 24");
    a_ins_single: assert property (s_reg.ctl[0][7:0] == EV_INS_RESP |=>
                                   ctr_inc[0] == {7'd0, $past(ev.ins[0])})
        else $error("insert event mismatch");
    a_stall_cnt: assert property (s_reg.ctl[1][7:0] == EV_ADDR_STALL |=>
                                  ctr_inc[1] == {7'd0, $past(ev.addr_stall)})
        else $error("credit stall mismatch");
    a_match_stall: assert property (s_reg.ctl[0] == {8'h01, EV_ADDR_MATCH} |=>
                                    ctr_inc[0] == {7'd0, $past(ev.conflict_stall)})
        else $error("conflict stall mismatch");
    a_match_merge: assert property (s_reg.ctl[0] == {8'h02, EV_ADDR_MATCH} |=>
                                    ctr_inc[0] == {7'd0, $past(ev.conflict_merge)})
        else $error("conflict merge mismatch");
    a_ack_tickle: assert property (wc.own_ack[0] == 1'b0 && wc.wr_done[0] == 1'b0
                                   && s_reg.ack[0] >= 8'h07 |=>
                                   s_reg.ack[0] == $past(s_reg.ack[0]) - {5'd0, $past(wc.tickle_rel[0])})
        else $error("tickle release not applied");
    a_own_issue: assert property (wc.wr_issue[0] && !wc.wr_done[0] && s_reg.own[0] < 8'hff |=>
                                  s_reg.own[0] == $past(s_reg.own[0]) + 8'h01)
        else $error("ownership tracker did not rise");
    a_ctl_write: assert property (wr_en && addr == ADDR_CTL1 |=>
                                  s_reg.ctl[1] == $past(wdata[15:0]))
        else $error("control write lost");
endmodule : iopes_top
`default_nettype wire

// File: shared/iopes_pkg.sv
// Package for the I/O ring-port performance event selector
package iopes_pkg;
    // ========================================
    // Control field layout
    localparam int CTL_EV_LSB    = 0;
    localparam int CTL_UMASK_LSB = 8;
    localparam int CTL_W         = 16;
    localparam int NUM_CTRS      = 2;
    localparam int OCC_W         = 8;
    localparam int INC_W         = 8;
    localparam int NUM_SRC       = 4;
    localparam int SRC_W         = 2;
    // ========================================
    // Per-cycle maxima
    localparam logic [7:0] MAX_ONE   = 8'h01;
    localparam logic [7:0] MAX_QUEUE = 8'h18;
    localparam logic [7:0] MAX_CACHE = 8'h80;
    // ========================================
    // Register map of the plain port
    localparam logic [3:0] ADDR_CTL0   = 4'h0;
    localparam logic [3:0] ADDR_CTL1   = 4'h1;
    localparam logic [3:0] ADDR_FILTER = 4'h2;
    localparam logic [3:0] ADDR_INC0   = 4'h3;
    localparam logic [3:0] ADDR_INC1   = 4'h4;
    localparam logic [15:0] CTL_RESET  = 16'h0000;
    // ========================================
    // Event codes
    localparam logic [7:0] EV_CLOCK      = 8'h00;
    localparam logic [7:0] EV_INS_RESP   = 8'h01;
    localparam logic [7:0] EV_INS_NCB    = 8'h02;
    localparam logic [7:0] EV_INS_NCS    = 8'h03;
    localparam logic [7:0] EV_FULL_RESP  = 8'h04;
    localparam logic [7:0] EV_FULL_NCS   = 8'h06;
    localparam logic [7:0] EV_OCC_RESP   = 8'h07;
    localparam logic [7:0] EV_OCC_NCS    = 8'h09;
    localparam logic [7:0] EV_ACK_INS    = 8'h0a;
    localparam logic [7:0] EV_ACK_FULL   = 8'h0b;
    localparam logic [7:0] EV_ACK_OCC    = 8'h0c;
    localparam logic [7:0] EV_OUT_REQ    = 8'h0d;
    localparam logic [7:0] EV_OUT_NCB    = 8'h0e;
    localparam logic [7:0] EV_OUT_NCS    = 8'h0f;
    localparam logic [7:0] EV_C_READ     = 8'h10;
    localparam logic [7:0] EV_C_WRITE    = 8'h11;
    localparam logic [7:0] EV_C_TOTAL    = 8'h12;
    localparam logic [7:0] EV_C_OWN      = 8'h13;
    localparam logic [7:0] EV_C_ACKPEND  = 8'h14;
    localparam logic [7:0] EV_ADDR_MATCH = 8'h17;
    localparam logic [7:0] EV_ADDR_STALL = 8'h18;
    localparam logic [7:0] EV_DATA_STALL = 8'h19;
    localparam logic [7:0] UM_ANY        = 8'h01;
    localparam logic [7:0] UM_SOURCE     = 8'h02;
    // ========================================
    // Unit status bundle, one cycle's view
    typedef struct packed {
        logic [2:0]       ins;        // Data ingress inserts per class
        logic [2:0]       full;       // Data ingress full per class
        logic [2:0][4:0]  occ;        // Data ingress occupancy per class
        logic             ack_ins;
        logic             ack_full;
        logic [4:0]       ack_occ;
        logic             out_req;
        logic [1:0]       out_ins;
        logic             addr_stall;
        logic             data_stall;
        logic             conflict_stall;
        logic             conflict_merge;
    } iopes_ev_t;
    // Write-cache tracker events per source port
    typedef struct packed {
        logic [NUM_SRC-1:0] rd_issue;
        logic [NUM_SRC-1:0] rd_done;
        logic [NUM_SRC-1:0] wr_issue;
        logic [NUM_SRC-1:0] own_ack;
        logic [NUM_SRC-1:0] wr_done;
        logic [NUM_SRC-1:0][2:0] tickle_rel;
    } iopes_wc_t;
    typedef struct packed {
        logic [NUM_SRC-1:0][OCC_W-1:0] rd;
        logic [NUM_SRC-1:0][OCC_W-1:0] own;
        logic [NUM_SRC-1:0][OCC_W-1:0] ack;
        logic [NUM_CTRS-1:0][CTL_W-1:0] ctl;
        logic [SRC_W-1:0]              src_sel;
        logic [NUM_CTRS-1:0][INC_W-1:0] inc;
        logic [31:0]                    rdata;
    } iopes_state_t;
endpackage : iopes_pkg

// File: sim/iopes_top_tb_top.sv
// Self-checking bench for the performance event selector
`timescale 1ns/1ns
`default_nettype none
module iopes_top_tb_top;
    import iopes_pkg::*;
    // ========================================
    // Stimulus and hookup
    logic                           clk      = 1'b0;
    logic                           rst_n    = 1'b0;
    logic [3:0]                     addr     = 4'h0;
    logic [31:0]                    wdata    = 32'h0000_0000;
    logic                           wr_en    = 1'b0;
    logic                           rd_en    = 1'b0;
    logic [31:0]                    rdata;
    iopes_ev_t                      ev       = '0;
    iopes_wc_t                      wc       = '0;
    logic [NUM_CTRS-1:0][INC_W-1:0] ctr_inc;
    int                             failures = 0;
    int                             compares = 0;
    // Half period of a 4 ns clock
    always #2 clk = ~clk;
    iopes_top dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .ev(ev), .wc(wc), .ctr_inc(ctr_inc));
    // ========================================
    // Bus and check tasks
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    // Read data is only valid in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        compares++;
        if (rdata !== exp) begin
            failures++;
            $display("BAD rdata at %h exp %h got %h", a, exp, rdata);
        end
    endtask : rd_chk
    task automatic chk_inc(input int c, input logic [7:0] exp);
        compares++;
        if (ctr_inc[c] !== exp) begin
            failures++;
            $display("BAD ctr_inc%0d exp %h got %h", c, exp, ctr_inc[c]);
        end
    endtask : chk_inc
    // Selection takes two cycles to reach the increment, the first inside wr; two spare
    task automatic sel_chk(input int c, input logic [7:0] um, code, exp);
        wr((c == 0) ? ADDR_CTL0 : ADDR_CTL1, {16'h0000, um, code});
        repeat (3) @(posedge clk);
        #1;
        chk_inc(c, exp);
    endtask : sel_chk
    // Kind 0..4 picks a 4-bit port mask field, kind 7 the tickle counts
    task automatic pulse(input int kind, input logic [11:0] v, input int n);
        @(posedge clk);
        wc <= iopes_wc_t'(32'(v) << (4 * (7 - kind)));
        repeat (n) @(posedge clk);
        wc <= '0;
    endtask : pulse
    // Independent view of what each status event should add
    function automatic logic [7:0] ev_exp(input logic [7:0] code, um, input iopes_ev_t e);
        logic [4:0] q;
        q = (code == EV_OCC_RESP) ? e.occ[0] : (code == 8'h08) ? e.occ[1] : e.occ[2];
        case (code) inside
            EV_CLOCK:                   return 8'h01;
            [EV_INS_RESP:EV_INS_NCS]:   return 8'(e.ins[code[1:0] - 2'd1]);
            [EV_FULL_RESP:EV_FULL_NCS]: return 8'(e.full[code[1:0]]);
            [EV_OCC_RESP:EV_OCC_NCS]:   return (q > 5'd24) ? MAX_QUEUE : 8'(q);
            EV_ACK_INS:                 return 8'(e.ack_ins);
            EV_ACK_FULL:                return 8'(e.ack_full);
            EV_ACK_OCC:                 return (e.ack_occ > 5'd24) ? MAX_QUEUE : 8'(e.ack_occ);
            EV_OUT_REQ:                 return 8'(e.out_req);
            EV_OUT_NCB:                 return 8'(e.out_ins[0]);
            EV_OUT_NCS:                 return 8'(e.out_ins[1]);
            EV_ADDR_MATCH:              return 8'((um[0] & e.conflict_stall) | (um[1] & e.conflict_merge));
            EV_ADDR_STALL:              return 8'(e.addr_stall);
            EV_DATA_STALL:              return 8'(e.data_stall);
            default:                    return 8'h00;
        endcase
    endfunction : ev_exp
    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize
    // ========================================
    // Hang guard, far beyond the planned run
    initial begin
        #400000;
        failures++;
        summarize();
    end
    // ========================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk_inc(0, 8'h00);
        chk_inc(1, 8'h00);
        rd_chk(ADDR_CTL0, 32'h0000_0000);
        wr(ADDR_CTL0, 32'hffff_0117);
        rd_chk(ADDR_CTL0, 32'h0000_0117);
        wr(ADDR_FILTER, 32'h0000_0007);
        rd_chk(ADDR_FILTER, 32'h0000_0003);
        wr(4'h5, 32'hffff_ffff);
        rd_chk(4'h5, 32'h0000_0000);
        $display("test registers done");
        // Pattern, then its inverse, so no bit may be stuck either way
        ev.ins            <= 3'b101;
        ev.full           <= 3'b010;
        ev.occ            <= {5'd7, 5'd12, 5'd30};
        ev.ack_ins        <= 1'b1;
        ev.ack_occ        <= 5'd25;
        ev.out_req        <= 1'b1;
        ev.out_ins        <= 2'b10;
        ev.addr_stall     <= 1'b1;
        ev.conflict_stall <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 28; k++) begin
                sel_chk(k % 2, UM_ANY, 8'(k), ev_exp(8'(k), UM_ANY, ev));
            end
            sel_chk(1, UM_SOURCE, EV_ADDR_MATCH, ev_exp(EV_ADDR_MATCH, UM_SOURCE, ev));
            @(posedge clk);
            ev <= ~ev;
        end
        $display("test status events done");
        // Trackers: ack on port 0, ownership on 1, reads on 2
        pulse(3, 12'h001, 3);
        pulse(2, 12'h002, 2);
        pulse(0, 12'h004, 4);
        pulse(1, 12'h004, 1);
        wr(ADDR_FILTER, 32'h0000_0001);
        sel_chk(0, UM_ANY, EV_C_OWN, 8'd2);
        sel_chk(1, UM_SOURCE, EV_C_OWN, 8'd2);
        sel_chk(0, UM_ANY, EV_C_ACKPEND, 8'd3);
        sel_chk(1, UM_SOURCE, EV_C_ACKPEND, 8'd0);
        sel_chk(0, UM_ANY, EV_C_READ, 8'd3);
        sel_chk(1, UM_ANY, EV_C_WRITE, 8'd5);
        sel_chk(0, UM_ANY, EV_C_TOTAL, 8'd8);
        sel_chk(1, 8'h03, EV_C_OWN, 8'd0);
        wr(ADDR_FILTER, 32'h0000_0000);
        sel_chk(0, UM_SOURCE, EV_C_ACKPEND, 8'd3);
        sel_chk(1, UM_SOURCE, EV_C_OWN, 8'd0);
        // One tickle releasing two writes at once
        pulse(7, 12'h002, 1);
        sel_chk(0, UM_ANY, EV_C_ACKPEND, 8'd1);
        pulse(4, 12'h003, 1);
        sel_chk(1, UM_ANY, EV_C_ACKPEND, 8'd0);
        sel_chk(0, UM_ANY, EV_C_OWN, 8'd1);
        $display("test trackers done");
        // All ports reading: 163 outstanding must clamp at 128
        pulse(0, 12'h00f, 40);
        sel_chk(0, UM_ANY, EV_C_READ, MAX_CACHE);
        rd_chk(ADDR_INC0, 32'h0000_0080);
        wr(ADDR_FILTER, 32'h0000_0002);
        sel_chk(1, UM_SOURCE, EV_C_READ, 8'd43);
        sel_chk(0, UM_SOURCE, EV_C_TOTAL, 8'd43);
        $display("test clamp done");
        summarize();
    end
endmodule : iopes_top_tb_top
`default_nettype wire
